/* rtl/rss_clock_loss.sv */
// Missing-clock one-shot: times out when system clock edges stop arriving
`timescale 1ns/1ps
`include "rss_consts.svh"

module rss_clock_loss #(
   parameter int TIMEOUT_CYC = `RSS_MCD_TIMEOUT_CYC
) (
   input  wire logic clk,       // Free-running reference clock
   input  wire logic rst,       // Synchronous reset, active high
   input  wire logic enable,    // Detector armed
   input  wire logic edge_seen, // System clock edge observed this cycle
   output logic      timeout_ff // One-cycle timeout pulse
);
   localparam int CW = $clog2(TIMEOUT_CYC + 1);

   logic [CW-1:0] idle_cnt_ff;

   // Re-armed by every edge so only a real stall reaches the limit
   always_ff @(posedge clk) begin
      if (rst || !enable || edge_seen) begin
         idle_cnt_ff <= '0;
      end else if (idle_cnt_ff != CW'(TIMEOUT_CYC)) begin
         idle_cnt_ff <= idle_cnt_ff + CW'(1);
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         timeout_ff <= 1'b0;
      end else begin
         timeout_ff <= enable && !edge_seen && (idle_cnt_ff == CW'(TIMEOUT_CYC - 1));
      end
   end

endmodule // rss_clock_loss

/* rtl/rss_consts.svh */
// Offsets, field positions, reset values and timing counts of the reset source supervisor
`ifndef RSS_CONSTS_SVH
`define RSS_CONSTS_SVH

`define RSS_SUPPLY_MON_ADDR  8'hFF
`define RSS_RESET_SRC_ADDR   8'hEF

`define RSS_MON_EN_BIT       7
`define RSS_MON_STAT_BIT     6
`define RSS_MON_LVL_BIT      5

`define RSS_UNUSED_BIT       7
`define RSS_FERR_BIT         6
`define RSS_CMP_BIT          5
`define RSS_SW_BIT           4
`define RSS_WDT_BIT          3
`define RSS_MCD_BIT          2
`define RSS_POR_BIT          1
`define RSS_PIN_BIT          0

`define RSS_MON_EN_RST       1'b1
`define RSS_MON_LVL_RST      1'b0
`define RSS_START_ADDR       16'h0000

`define RSS_CLK_MHZ          200
`define RSS_MCD_TIMEOUT_US   100
`define RSS_MCD_TIMEOUT_CYC  (`RSS_MCD_TIMEOUT_US * `RSS_CLK_MHZ)
`define RSS_WDT_DIV          12
`define RSS_WDT_LIMIT        255
`define RSS_MIN_HOLD_CYC     4

`endif

/* rtl/rss_pkg.sv */
// Types shared by the reset source supervisor
package rss_pkg;

   typedef enum logic [2:0] {
      RSS_ST_RUN     = 3'b001,
      RSS_ST_HOLD    = 3'b010,
      RSS_ST_RELEASE = 3'b100
   } rss_state_t;

   typedef struct packed {
      logic flash_error_flag;
      logic cmp;
      logic sw;
      logic wdt;
      logic clock_loss_detector;
      logic por;
      logic pin;
   } rss_cause_t;

   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } rss_sfr_req_t;

   typedef struct packed {
      logic        valid;
      logic [15:0] addr;
   } rss_access_t;

endpackage

/* rtl/rss_top.sv */
// Reset source supervisor: collects reset requests and records the last cause
`timescale 1ns/1ps
`include "rss_consts.svh"

module rss_top #(
   parameter int          MCD_TIMEOUT_CYC = `RSS_MCD_TIMEOUT_CYC,
   parameter int          WDT_LIMIT       = `RSS_WDT_LIMIT,
   parameter logic [15:0] LOCK_ADDR       = 16'h1DFF
) (
   input  wire logic                 CLK,          // 200 MHz clock
   input  wire logic                 SYS_RST,      // Power-on reset, sync, active high
   input  wire rss_pkg::rss_sfr_req_t SFR_REQ,     // Register bus request
   output logic [7:0]                SFR_RDATA,    // Read data, one cycle after rd
   input  wire logic                 SUPPLY_OK,    // Supply monitor output, 1 above threshold
   input  wire logic                 CMP_OUT,      // Comparator, 1 when plus above minus
   input  wire logic                 RST_PIN_N,    // Reset pin level, low requests reset
   output logic                      RST_PIN_DRV,  // Reset pin drive value
   output logic                      RST_PIN_OE,   // Reset pin drive enable
   input  wire logic                 SYSCLK_EDGE,  // System clock edge seen
   input  wire logic                 WDT_SERVICE,  // Watchdog service pulse
   input  wire logic                 WDT_DISABLE,  // Watchdog disable pulse
   input  wire logic                 FLASH_WR_EN,  // Flash write enable
   input  wire rss_pkg::rss_access_t DATA_WR,      // Data-space write
   input  wire rss_pkg::rss_access_t CODE_RD,      // Code-space data read
   input  wire rss_pkg::rss_access_t FETCH,        // Instruction fetch or branch
   input  wire logic                 SEC_BLOCK,    // Access blocked by security
   input  wire logic                 FLASH_ERASE,  // Flash erase attempt
   output logic                      SYS_RESET,    // Merged system reset
   output logic                      CORE_START,   // Execution start pulse
   output logic [15:0]               START_ADDR,   // Execution start address
   output logic                      MON_ENABLE,   // Supply monitor power
   output logic                      MON_LVL_HIGH, // Supply threshold select
   output logic                      WDT_TICK      // Watchdog clock enable
);

   function automatic logic above_lock(input rss_pkg::rss_access_t acc);
      above_lock = acc.valid && (acc.addr > LOCK_ADDR);
   endfunction

   rss_pkg::rss_state_t state_ff;
   rss_pkg::rss_state_t nxt_state;
   rss_pkg::rss_cause_t cause_ff;
   rss_pkg::rss_cause_t nxt_cause;
   logic        mon_en_ff;
   logic        mon_lvl_ff;
   logic        mon_sel_ff;
   logic        cmp_sel_ff;
   logic        mcd_en_ff;
   logic        sw_req_ff;
   logic        pin_drive_ff;
   logic [2:0]  hold_cnt_ff;
   logic [3:0]  div_cnt_ff;
   logic        wdt_tick_ff;
   logic        wdt_en_ff;
   logic [7:0]  wdt_cnt_ff;
   logic        wdt_req_ff;
   logic        mcd_req;
   logic        run;
   logic        wr_mon;
   logic        wr_src;
   logic        req_pin;
   logic        req_sup;
   logic        req_cmp;
   logic        req_ferr;
   logic        level_req;
   logic        any_req;

   assign run    = (state_ff == rss_pkg::RSS_ST_RUN);
   assign wr_mon = run && SFR_REQ.wr && (SFR_REQ.addr == `RSS_SUPPLY_MON_ADDR);
   assign wr_src = run && SFR_REQ.wr && (SFR_REQ.addr == `RSS_RESET_SRC_ADDR);

   assign req_pin  = !RST_PIN_N && !pin_drive_ff;
   assign req_sup  = mon_en_ff && mon_sel_ff && !SUPPLY_OK;
   assign req_cmp  = cmp_sel_ff && !CMP_OUT;
   assign req_ferr = (FLASH_WR_EN && above_lock(DATA_WR))
                   || above_lock(CODE_RD) || above_lock(FETCH)
                   || SEC_BLOCK
                   || (!mon_en_ff && (FLASH_ERASE || (FLASH_WR_EN && DATA_WR.valid)));
   assign level_req = req_pin || req_sup || req_cmp;
   assign any_req   = level_req || req_ferr || mcd_req || wdt_req_ff || sw_req_ff;

   rss_clock_loss #(
      .TIMEOUT_CYC (MCD_TIMEOUT_CYC)
   ) u_clock_loss (
      .clk        (CLK),
      .rst        (SYS_RST),
      .enable     (mcd_en_ff && run),
      .edge_seen  (SYSCLK_EDGE),
      .timeout_ff (mcd_req)
   );

   // Priority picks a single cause when sources coincide
   always_comb begin
      nxt_cause = '0;
      if (req_sup) begin
         nxt_cause.por = 1'b1;
      end else if (req_pin) begin
         nxt_cause.pin = 1'b1;
      end else if (mcd_req) begin
         nxt_cause.clock_loss_detector = 1'b1;
      end else if (req_cmp) begin
         nxt_cause.cmp = 1'b1;
      end else if (wdt_req_ff) begin
         nxt_cause.wdt = 1'b1;
      end else if (req_ferr) begin
         nxt_cause.flash_error_flag = 1'b1;
      end else begin
         nxt_cause.sw = 1'b1;
      end
   end

   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         rss_pkg::RSS_ST_RUN: begin
            if (any_req) begin
               nxt_state = rss_pkg::RSS_ST_HOLD;
            end
         end
         rss_pkg::RSS_ST_HOLD: begin
            if (!level_req && hold_cnt_ff == 3'(`RSS_MIN_HOLD_CYC - 1)) begin
               nxt_state = rss_pkg::RSS_ST_RELEASE;
            end
         end
         rss_pkg::RSS_ST_RELEASE: begin
            nxt_state = rss_pkg::RSS_ST_RUN;
         end
         default: begin
            nxt_state = rss_pkg::RSS_ST_HOLD;
         end
      endcase
   end

   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         state_ff <= rss_pkg::RSS_ST_HOLD;
      end else begin
         state_ff <= nxt_state;
      end
   end

   // Pulse sources are short, so the hold counter stretches every reset
   always_ff @(posedge CLK) begin
      if (SYS_RST || state_ff != rss_pkg::RSS_ST_HOLD) begin
         hold_cnt_ff <= '0;
      end else if (hold_cnt_ff != 3'(`RSS_MIN_HOLD_CYC - 1)) begin
         hold_cnt_ff <= hold_cnt_ff + 3'h1;
      end
   end

   // Captured only on entry so software always sees the latest cause
   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         cause_ff <= '{por: 1'b1, default: 1'b0};
      end else if (run && any_req) begin
         cause_ff <= nxt_cause;
      end
   end

   // Monitor enable and threshold survive every reset but power-on
   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         mon_en_ff  <= `RSS_MON_EN_RST;
         mon_lvl_ff <= `RSS_MON_LVL_RST;
      end else if (wr_mon) begin
         mon_en_ff  <= SFR_REQ.wdata[`RSS_MON_EN_BIT];
         mon_lvl_ff <= SFR_REQ.wdata[`RSS_MON_LVL_BIT];
      end
   end

   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         mon_sel_ff <= 1'b0;
      end else if (wr_src) begin
         mon_sel_ff <= SFR_REQ.wdata[`RSS_POR_BIT];
      end
   end

   // Comparator and clock-loss selects fall back to off on every reset
   always_ff @(posedge CLK) begin
      if (SYS_RST || (run && any_req)) begin
         cmp_sel_ff <= 1'b0;
         mcd_en_ff  <= 1'b0;
      end else if (wr_src) begin
         cmp_sel_ff <= SFR_REQ.wdata[`RSS_CMP_BIT];
         mcd_en_ff  <= SFR_REQ.wdata[`RSS_MCD_BIT];
      end
   end

   always_ff @(posedge CLK) begin
      if (SYS_RST || !run) begin
         sw_req_ff <= 1'b0;
      end else begin
         sw_req_ff <= wr_src && SFR_REQ.wdata[`RSS_SW_BIT];
      end
   end

   // Divider for the watchdog tick runs through every reset but power-on
   always_ff @(posedge CLK) begin
      if (SYS_RST || div_cnt_ff == 4'(`RSS_WDT_DIV - 1)) begin
         div_cnt_ff <= '0;
      end else begin
         div_cnt_ff <= div_cnt_ff + 4'h1;
      end
   end

   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         wdt_tick_ff <= 1'b0;
      end else begin
         wdt_tick_ff <= (div_cnt_ff == 4'(`RSS_WDT_DIV - 1));
      end
   end

   always_ff @(posedge CLK) begin
      if (SYS_RST || !run) begin
         wdt_en_ff <= 1'b1;
      end else if (WDT_DISABLE) begin
         wdt_en_ff <= 1'b0;
      end
   end

   always_ff @(posedge CLK) begin
      if (SYS_RST || !run || WDT_SERVICE || !wdt_en_ff) begin
         wdt_cnt_ff <= '0;
      end else if (wdt_tick_ff) begin
         wdt_cnt_ff <= wdt_cnt_ff + 8'h01;
      end
   end

   always_ff @(posedge CLK) begin
      if (SYS_RST || !run) begin
         wdt_req_ff <= 1'b0;
      end else begin
         wdt_req_ff <= wdt_en_ff && !WDT_SERVICE && wdt_tick_ff
                       && (wdt_cnt_ff == 8'(WDT_LIMIT));
      end
   end

   // Pin is pulled low only for power-on and supply resets
   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         pin_drive_ff <= 1'b1;
      end else if (run && any_req) begin
         pin_drive_ff <= req_sup;
      end else if (nxt_state == rss_pkg::RSS_ST_RELEASE || run) begin
         pin_drive_ff <= 1'b0;
      end
   end

   assign RST_PIN_OE = pin_drive_ff;

   always_ff @(posedge CLK) begin
      RST_PIN_DRV <= 1'b0;
   end

   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         SYS_RESET  <= 1'b1;
         CORE_START <= 1'b0;
      end else begin
         SYS_RESET  <= (nxt_state != rss_pkg::RSS_ST_RUN);
         CORE_START <= (state_ff == rss_pkg::RSS_ST_RELEASE);
      end
   end

   always_ff @(posedge CLK) begin
      START_ADDR <= `RSS_START_ADDR;
   end

   assign MON_ENABLE   = mon_en_ff;
   assign MON_LVL_HIGH = mon_lvl_ff;
   assign WDT_TICK     = wdt_tick_ff;

   // Reserved monitor bits read as zero
   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         SFR_RDATA <= '0;
      end else if (SFR_REQ.rd && SFR_REQ.addr == `RSS_SUPPLY_MON_ADDR) begin
         SFR_RDATA <= {mon_en_ff, SUPPLY_OK, mon_lvl_ff, 5'h00};
      end else if (SFR_REQ.rd && SFR_REQ.addr == `RSS_RESET_SRC_ADDR) begin
         SFR_RDATA <= {1'b1, cause_ff};
      end else if (SFR_REQ.rd) begin
         SFR_RDATA <= '0;
      end
   end

   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (SYS_RST);

   sw_reset_a: assert property (wr_src && SFR_REQ.wdata[4]
                                |-> ##2 SYS_RESET && cause_ff.sw)
      else $error("software reset not taken");
   cause_hold_a: assert property (run && $past(run) |-> $stable(cause_ff))
      else $error("cause changed outside reset entry");
   pin_float_a: assert property (SYS_RESET && !cause_ff.por |-> !RST_PIN_OE)
      else $error("reset pin driven by internal reset");
   supply_stat_a: assert property (SFR_REQ.rd && SFR_REQ.addr == 8'hFF
                                   |=> SFR_RDATA[6] == $past(SUPPLY_OK))
      else $error("supply status not live");
   mon_gate_a: assert property (run && !mon_sel_ff && !SUPPLY_OK
                                |=> !(SYS_RESET && cause_ff.por))
      else $error("unselected monitor caused reset");
   cmp_reset_a: assert property (run && cmp_sel_ff && !CMP_OUT && !req_sup && !req_pin
                                 && !mcd_req |=> cause_ff.cmp ##1 SYS_RESET)
      else $error("comparator reset missed");
   flash_err_a: assert property (run && req_ferr && !level_req && !mcd_req
                                 && !wdt_req_ff |=> cause_ff.flash_error_flag)
      else $error("flash error flag not set");
   start_pulse_a: assert property ($fell(SYS_RESET)
                                   |-> CORE_START && START_ADDR == 16'h0000)
      else $error("start not at zero");
   wdt_tick_a: assert property (WDT_TICK |-> ##12 WDT_TICK)
      else $error("watchdog tick not divide by 12");
   pin_flag_a: assert property (run && req_pin && !req_sup
                                |=> cause_ff.pin ##1 SYS_RESET)
      else $error("pin reset flag not set");

   sw_cover_c:  cover property (wr_src && SFR_REQ.wdata[4] ##2 SYS_RESET);
   mcd_cover_c: cover property (mcd_req ##1 cause_ff.clock_loss_detector);
   wdt_cover_c: cover property (wdt_req_ff ##1 cause_ff.wdt);

endmodule // rss_top

/* sim/rss_pin_driver.sv */
// External reset circuitry model: pulls the active-low reset pin low for a commanded span
`timescale 1ns/1ps

module rss_pin_driver (
   input  wire logic       clk,       // Bench clock
   input  wire logic       start,     // Begin a low pulse
   input  wire logic [7:0] len,       // Pulse length in cycles
   input  wire logic       dev_out,   // Device pin drive value
   input  wire logic       dev_oe,    // Device pin drive enable
   output logic            pin_level  // Resolved pin level
);
   logic [7:0] cnt_ff = 8'h00;

   always_ff @(posedge clk) begin
      if (start) begin
         cnt_ff <= len;
      end else if (cnt_ff != 8'h00) begin
         cnt_ff <= cnt_ff - 8'h01;
      end
   end

   // Pin has a pull-up, so it reads high whenever nobody pulls it low
   assign pin_level = ~((cnt_ff != 8'h00) | (dev_oe & ~dev_out));
endmodule // rss_pin_driver

/* sim/tb_rss_top.sv */
// Self-checking bench for the reset source supervisor
`timescale 1ns/1ps
`include "rss_consts.svh"

module tb_rss_top;
   localparam int          CLOCK_LOSS_DETECTOR  = 50;
   localparam logic [15:0] LOCK = 16'h1DFF;
   logic clk = 1'b0, sys_rst = 1'b1, supply_ok = 1'b1, cmp_out = 1'b1, sysclk_edge = 1'b1;
   logic svc = 1'b1, wdt_dis = 1'b0, flash_wr_en = 1'b0, sec_block = 1'b0, flash_erase = 1'b0;
   logic pin_start = 1'b0;
   logic [7:0] pin_len = 8'h01;
   rss_pkg::rss_sfr_req_t sfr_req = '0;
   rss_pkg::rss_access_t  data_wr = '0, code_rd = '0, fetch = '0;
   logic [7:0]  rdata;
   logic [15:0] start_addr;
   logic pin_out, pin_oe, pin_level, sys_reset, core_start, mon_en, mon_hi, wdt_tick;
   int errors = 0, n_checks = 0, i, k;

   always #2.5 clk = ~clk;

   rss_top #(.MCD_TIMEOUT_CYC(CLOCK_LOSS_DETECTOR), .WDT_LIMIT(3), .LOCK_ADDR(LOCK)) rss_top_i (
      .CLK(clk), .SYS_RST(sys_rst), .SFR_REQ(sfr_req), .SFR_RDATA(rdata),
      .SUPPLY_OK(supply_ok), .CMP_OUT(cmp_out), .RST_PIN_N(pin_level),
      .RST_PIN_DRV(pin_out), .RST_PIN_OE(pin_oe), .SYSCLK_EDGE(sysclk_edge),
      .WDT_SERVICE(svc), .WDT_DISABLE(wdt_dis), .FLASH_WR_EN(flash_wr_en),
      .DATA_WR(data_wr), .CODE_RD(code_rd), .FETCH(fetch), .SEC_BLOCK(sec_block),
      .FLASH_ERASE(flash_erase), .SYS_RESET(sys_reset), .CORE_START(core_start),
      .START_ADDR(start_addr), .MON_ENABLE(mon_en), .MON_LVL_HIGH(mon_hi), .WDT_TICK(wdt_tick));

   rss_pin_driver rss_pin_driver_i (
      .clk(clk), .start(pin_start), .len(pin_len), .dev_out(pin_out), .dev_oe(pin_oe),
      .pin_level(pin_level));

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_checks++;
      if (got !== exp) begin
         errors++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   // Request is dropped one cycle before the next may start, so no signal is set twice at once
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      sfr_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      cyc(1);
      sfr_req = '0;
      cyc(1);
   endtask

   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      sfr_req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
      cyc(1);
      sfr_req = '0;
      cyc(1);
      chk(16'(rdata), 16'(e));
   endtask

   task automatic expect_reset(input logic [7:0] cause, input logic oe);
      i = 0;
      while (sys_reset !== 1'b1 && i < 300) begin
         cyc(1);
         i++;
      end
      svc = 1'b1;
      chk(16'(sys_reset), 16'h0001);
      chk(16'(pin_oe), 16'(oe));
      i = 0;
      while (sys_reset !== 1'b0 && i < 300) begin
         cyc(1);
         i++;
      end
      chk(16'(core_start), 16'h0001);
      chk(start_addr, `RSS_START_ADDR);
      rd(8'hEF, cause);
   endtask

   task automatic report_and_stop;
      $display("checks %0d errors %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   // Whole run is a few hundred cycles; this span is far beyond it
   initial begin
      #50000;
      errors++;
      report_and_stop;
   end

   initial begin
      cyc(3);
      sys_rst = 1'b0;
      expect_reset(8'h82, 1'b1);
      rd(8'hFF, 8'hC0);
      wr(8'hFF, 8'hBF);
      rd(8'hFF, 8'hE0);
      chk(16'({mon_en, mon_hi}), 16'h0003);
      supply_ok = 1'b0;
      cyc(3);
      rd(8'hFF, 8'hA0);
      chk(16'(sys_reset), 16'h0000);
      supply_ok = 1'b1;
      i = 0;
      while (wdt_tick !== 1'b1 && i < 20) begin
         cyc(1);
         i++;
      end
      cyc(1);
      i = 0;
      while (wdt_tick !== 1'b1 && i < 20) begin
         cyc(1);
         i++;
      end
      chk(16'(i + 1), 16'h000C);
      $display("done: power-on and monitor");
      wr(8'hEF, 8'h10);
      cyc(1);
      sec_block = 1'b1;
      cyc(1);
      sec_block = 1'b0;
      // Lands while reset is still held, so the monitor settings must survive it
      wr(8'hFF, 8'h00);
      expect_reset(8'h90, 1'b0);
      chk(16'({mon_en, mon_hi}), 16'h0003);
      for (k = 0; k < 2; k++) begin
         pin_len = (k == 0) ? 8'h01 : 8'h28;
         pin_start = 1'b1;
         cyc(1);
         pin_start = 1'b0;
         expect_reset(8'h81, 1'b0);
      end
      $display("done: software and pin");
      cmp_out = 1'b0;
      cyc(3);
      chk(16'(sys_reset), 16'h0000);
      cmp_out = 1'b1;
      wr(8'hEF, 8'h20);
      cmp_out = 1'b0;
      cyc(3);
      cmp_out = 1'b1;
      expect_reset(8'hA0, 1'b0);
      $display("done: comparator");
      sysclk_edge = 1'b0;
      cyc(CLOCK_LOSS_DETECTOR + 10);
      chk(16'(sys_reset), 16'h0000);
      sysclk_edge = 1'b1;
      wr(8'hEF, 8'h04);
      sysclk_edge = 1'b0;
      cyc(CLOCK_LOSS_DETECTOR - 5);
      chk(16'(sys_reset), 16'h0000);
      // Stall is kept until the reset has been seen; the detector has not timed out yet and an edge now would re-arm it
      expect_reset(8'h84, 1'b0);
      sysclk_edge = 1'b1;
      $display("done: clock loss");
      svc = 1'b0;
      expect_reset(8'h88, 1'b0);
      wdt_dis = 1'b1;
      svc = 1'b0;
      cyc(1);
      wdt_dis = 1'b0;
      cyc(100);
      chk(16'(sys_reset), 16'h0000);
      wr(8'hEF, 8'h10);
      expect_reset(8'h90, 1'b0);
      svc = 1'b0;
      expect_reset(8'h88, 1'b0);
      $display("done: watchdog");
      code_rd = '{valid: 1'b1, addr: LOCK};
      data_wr = '{valid: 1'b1, addr: LOCK + 16'h0001};
      cyc(1);
      code_rd = '0;
      data_wr = '0;
      cyc(3);
      chk(16'(sys_reset), 16'h0000);
      for (k = 0; k < 5; k++) begin
         if (k == 4) begin
            wr(8'hFF, 8'h00);
         end
         case (k)
            0: begin
               flash_wr_en = 1'b1;
               data_wr = '{valid: 1'b1, addr: LOCK + 16'h0001};
            end
            1: code_rd = '{valid: 1'b1, addr: LOCK + 16'h0001};
            2: fetch = '{valid: 1'b1, addr: 16'hFFFF};
            3: sec_block = 1'b1;
            default: flash_erase = 1'b1;
         endcase
         cyc(1);
         {flash_wr_en, sec_block, flash_erase} = 3'h0;
         data_wr = '0;
         code_rd = '0;
         fetch = '0;
         expect_reset(8'hC0, 1'b0);
      end
      $display("done: flash error");
      wr(8'hFF, 8'hA0);
      wr(8'hEF, 8'h02);
      supply_ok = 1'b0;
      cyc(3);
      chk(16'({pin_oe, pin_level}), 16'h0002);
      supply_ok = 1'b1;
      expect_reset(8'h82, 1'b1);
      rd(8'hFF, 8'hE0);
      $display("done: supply monitor");
      report_and_stop;
   end
endmodule // tb_rss_top
